/* ffc_classifier.sv */
// Registered unpacker and classifier for three floating-point formats.
// Assumes the datapath presents one operand per cycle on the core clock;
// results appear one cycle after the operand is offered.
`timescale 1ns/10ps
module ffc_classifier
  import ffc_pkg::*;
(
  input  wire logic               core_clk_in,
  input  wire logic               rst_b_in,
  input  wire logic               op_valid_in,
  input  wire logic [1:0]         op_fmt_in,
  input  wire logic [79:0]        op_data_in,
  output logic                    res_valid_out,
  output logic                    sign_out,
  output logic [14:0]             exp_biased_out,
  output logic signed [16:0]      exp_true_out,
  output logic                    int_bit_out,
  output logic [62:0]             frac_out,
  output logic                    is_zero_out,
  output logic                    is_denorm_out,
  output logic                    is_inf_out,
  output logic                    is_snan_out,
  output logic                    is_qnan_out,
  output logic                    is_indef_out,
  output logic [3:0]              mem_bytes_out,
  output logic                    scalar_ok_out,
  output logic                    simd_ok_out
);
  logic        sgn;
  logic [14:0] ex;
  logic [14:0] ex_max;
  logic [62:0] fr;
  logic        ib;
  logic signed [16:0] bias;
  logic [3:0]  nb;
  logic        fmt_ok;
  logic        ex_all1;
  logic        ex_zero;
  logic        fr_zero;
  logic        fr_top;
  logic        fr_rest0;

  // Every check below samples on the core clock and sleeps in reset
  default clocking cb_core @(posedge core_clk_in);
  endclocking
  default disable iff (!rst_b_in);

  // Field extraction; fraction is left-aligned so its top bit is bit 62
  always_comb begin
    sgn    = 1'b0;
    ex     = 15'h0000;
    ex_max = 15'h7FFF;
    fr     = 63'h0;
    ib     = 1'b0;
    bias   = FFC_BIAS_EP;
    nb     = FFC_BYTES_EP;
    fmt_ok = 1'b1;
    unique case (ffc_fmt_t'(op_fmt_in))
      FFC_FMT_SINGLE: begin
        sgn    = op_data_in[FFC_SP_SIGN]; // RULE_08
        ex     = {7'h00, op_data_in[30:23]};
        ex_max = 15'h00FF;
        fr     = {op_data_in[22:0], 40'h0};
        ib     = (ex != 15'h0000); // RULE_03
        bias   = FFC_BIAS_SP;
        nb     = FFC_BYTES_SP; // RULE_02
      end
      FFC_FMT_DOUBLE: begin
        sgn    = op_data_in[FFC_DP_SIGN]; // RULE_08
        ex     = {4'h0, op_data_in[62:52]};
        ex_max = 15'h07FF;
        fr     = {op_data_in[51:0], 11'h000};
        ib     = (ex != 15'h0000); // RULE_03
        bias   = FFC_BIAS_DP;
        nb     = FFC_BYTES_DP; // RULE_02
      end
      FFC_FMT_EXT: begin
        sgn    = op_data_in[FFC_EP_SIGN]; // RULE_08
        ex     = op_data_in[78:64];
        ib     = op_data_in[FFC_EP_INT]; // RULE_06
        fr     = op_data_in[FFC_EP_FTOP:0]; // RULE_06
        bias   = FFC_BIAS_EP;
        nb     = FFC_BYTES_EP; // RULE_02
      end
      FFC_FMT_BAD: begin
        fmt_ok = 1'b0; // Reserved code: nothing is classified
        nb     = 4'h0;
      end
    endcase
  end

  // Class terms shared by the flags below
  assign ex_all1  = (ex == ex_max);
  assign ex_zero  = (ex == 15'h0000);
  assign fr_zero  = (fr == 63'h0);
  assign fr_top   = fr[62];
  assign fr_rest0 = (fr[61:0] == 62'h0);

  // Valid tracks the operand strobe
  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      res_valid_out <= 1'b0;
    end else begin
      res_valid_out <= op_valid_in;
    end
  end

  // Unpacked fields; held when no operand is offered to save toggling
  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      sign_out       <= 1'b0;
      exp_biased_out <= FFC_EXP_RST;
      exp_true_out   <= FFC_ETRUE_RST;
      int_bit_out    <= 1'b0;
      frac_out       <= FFC_FRAC_RST;
      mem_bytes_out  <= FFC_BYTES_RST;
    end else if (op_valid_in) begin
      sign_out       <= sgn & fmt_ok; // RULE_08
      exp_biased_out <= ex;
      exp_true_out   <= $signed({2'b00, ex}) - bias; // RULE_01
      int_bit_out    <= ib & fmt_ok; // RULE_07
      frac_out       <= fr;
      mem_bytes_out  <= nb; // RULE_02
    end
  end

  // Class flags; a stored extended integer bit is trusted as given
  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      is_zero_out   <= 1'b0;
      is_denorm_out <= 1'b0;
      is_inf_out    <= 1'b0;
      is_snan_out   <= 1'b0;
      is_qnan_out   <= 1'b0;
      is_indef_out  <= 1'b0;
    end else if (op_valid_in) begin
      is_zero_out   <= fmt_ok & ex_zero & fr_zero; // RULE_07
      is_denorm_out <= fmt_ok & ex_zero & !fr_zero; // RULE_07
      is_inf_out    <= fmt_ok & ex_all1 & fr_zero;
      is_snan_out   <= fmt_ok & ex_all1 & !fr_zero & !fr_top; // RULE_04
      is_qnan_out   <= fmt_ok & ex_all1 & fr_top; // RULE_09
      is_indef_out  <= fmt_ok & ex_all1 & fr_top & fr_rest0 & sgn; // RULE_09
    end
  end

  // Unit acceptance: packed units never take the extended format
  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      scalar_ok_out <= 1'b0;
      simd_ok_out   <= 1'b0;
    end else if (op_valid_in) begin
      scalar_ok_out <= fmt_ok; // RULE_05
      simd_ok_out   <= (op_fmt_in == FFC_FMT_SINGLE) ||
                       (op_fmt_in == FFC_FMT_DOUBLE); // RULE_05
    end
  end

  // Checks against the datapath result one cycle after the operand;
  // each trigger is one accepted operand of a given format
  sequence s_take_sp;
    op_valid_in && op_fmt_in == FFC_FMT_SINGLE;
  endsequence
  sequence s_take_dp;
    op_valid_in && op_fmt_in == FFC_FMT_DOUBLE;
  endsequence
  sequence s_take_ep;
    op_valid_in && op_fmt_in == FFC_FMT_EXT;
  endsequence

  // Valid is a one-cycle echo of the strobe
  a_valid_pulse: assert property (
    op_valid_in |=> res_valid_out)
    else $error("result valid missing");
  a_valid_idle: assert property (
    !op_valid_in |=> !res_valid_out)
    else $error("result valid without operand");
  // Idle cycles must not disturb the last result
  a_hold_fields: assert property (
    !op_valid_in |=> $stable(frac_out) && $stable(exp_true_out))
    else $error("fields changed while idle");

  // Expectations rebuilt from the raw operand, except a_snan_flag, a_zero_int, a_indef_qnan and a_qnan_excl, which use outputs
  a_bias_sub: assert property ( // RULE_01
    s_take_sp |=> exp_true_out ==
      $signed({9'h000, $past(op_data_in[30:23])}) - FFC_BIAS_SP)
    else $error("single exponent bias wrong");
  a_bias_ext: assert property ( // RULE_01
    s_take_ep |=> exp_true_out ==
      $signed({2'b00, $past(op_data_in[78:64])}) - FFC_BIAS_EP)
    else $error("extended exponent bias wrong");
  a_mem_bytes: assert property ( // RULE_02
    s_take_ep |=> mem_bytes_out == 4'hA)
    else $error("extended byte count wrong");
  a_bytes_sp: assert property ( // RULE_02
    s_take_sp |=> mem_bytes_out == 4'h4)
    else $error("single byte count wrong");
  a_implied_int: assert property ( // RULE_03
    s_take_dp |=> int_bit_out == ($past(op_data_in[62:52]) != 11'h000))
    else $error("implied integer bit wrong");
  a_snan_flag: assert property ( // RULE_04
    res_valid_out && is_snan_out |-> !frac_out[62] && frac_out != 63'h0)
    else $error("signalling NaN misflagged");
  a_snan_exact: assert property ( // RULE_04
    s_take_sp |=> is_snan_out == ($past(op_data_in[30:22]) == 9'h1FE &&
      $past(op_data_in[21:0]) != 22'h000000))
    else $error("single signalling NaN decode wrong");
  a_simd_ext: assert property ( // RULE_05
    s_take_ep |=> !simd_ok_out && scalar_ok_out)
    else $error("extended accepted by packed unit");
  a_simd_sp: assert property ( // RULE_05
    s_take_sp |=> simd_ok_out && scalar_ok_out)
    else $error("single refused by a unit");
  a_ext_fields: assert property ( // RULE_06
    s_take_ep |=> int_bit_out == $past(op_data_in[63]) &&
      frac_out[62] == $past(op_data_in[62]))
    else $error("extended field position wrong");
  a_implied_sp: assert property ( // RULE_07
    s_take_sp |=> int_bit_out == ($past(op_data_in[30:23]) != 8'h00))
    else $error("single integer bit wrong");
  a_zero_int: assert property ( // RULE_07
    res_valid_out && (is_zero_out || is_denorm_out) && !$past(op_fmt_in[1])
    |-> !int_bit_out)
    else $error("integer bit set on zero or denormal");
  a_sign_map: assert property ( // RULE_08
    s_take_sp |=> sign_out == $past(op_data_in[31]))
    else $error("sign decode wrong");
  a_sign_ep: assert property ( // RULE_08
    s_take_ep |=> sign_out == $past(op_data_in[79]))
    else $error("extended sign decode wrong");
  a_indef_qnan: assert property ( // RULE_09
    res_valid_out && is_indef_out |-> is_qnan_out && sign_out && !is_snan_out)
    else $error("indefinite not a negative quiet NaN");
  a_qnan_excl: assert property ( // RULE_09
    res_valid_out && is_qnan_out |-> !is_snan_out && !is_inf_out)
    else $error("quiet NaN shares another class");
endmodule : ffc_classifier

/* ffc_feed.sv */
// Partner model: load/store datapath offering one operand per request.
// Assumes the bench raises go_in for one cycle per operand.
`timescale 1ns/10ps
module ffc_feed (
  input  wire logic        clk_in,
  input  wire logic        go_in,
  input  wire logic [1:0]  fmt_in,
  input  wire logic [79:0] data_in,
  output logic             valid_out,
  output logic [1:0]       fmt_out,
  output logic [79:0]      data_out
);
  // Known values at time zero, before the first edge
  initial begin
    valid_out = 1'b0;
    fmt_out = 2'h0;
    data_out = 80'h0;
  end
  // An idle bus inverts its previous value every cycle, so stale data is seen
  always @(posedge clk_in) begin
    valid_out <= go_in;
    fmt_out   <= go_in ? fmt_in : ~fmt_out;
    data_out  <= go_in ? data_in : ~data_out;
  end
endmodule : ffc_feed

/* ffc_pkg.sv */
// Constants and types for the floating-point format classifier.
// Assumes operands arrive right-aligned in an 80-bit word.
// Overview of operation
// [RULE_01] True exponent is biased field minus bias
// [RULE_02] Memory size is 4, 8, 10 bytes
// [RULE_03] Rebuild implied integer bit for single, double
// [RULE_04] Signalling NaN: max exponent, fraction top clear
// [RULE_05] Extended precision accepted by scalar unit only
// [RULE_06] Extended integer bit 63, fraction top 62
// [RULE_07] Integer bit one unless zero or denormal; extended passes its stored bit 63 through unchanged
// [RULE_08] Sign zero positive, one negative
// [RULE_09] Quiet NaN and default indefinite NaN flags
package ffc_pkg;
  typedef enum logic [1:0] {
    FFC_FMT_SINGLE,
    FFC_FMT_DOUBLE,
    FFC_FMT_EXT,
    FFC_FMT_BAD
  } ffc_fmt_t;

  localparam logic signed [16:0] FFC_BIAS_SP = 17'sh0007F;
  localparam logic signed [16:0] FFC_BIAS_DP = 17'sh003FF;
  localparam logic signed [16:0] FFC_BIAS_EP = 17'sh03FFF;
  localparam logic [3:0] FFC_BYTES_SP = 4'h4;
  localparam logic [3:0] FFC_BYTES_DP = 4'h8;
  localparam logic [3:0] FFC_BYTES_EP = 4'hA;
  localparam int FFC_SP_SIGN = 31;
  localparam int FFC_DP_SIGN = 63;
  localparam int FFC_EP_SIGN = 79;
  localparam int FFC_EP_INT  = 63;
  localparam int FFC_EP_FTOP = 62;
  localparam logic [14:0] FFC_EXP_RST  = 15'h0000;
  localparam logic [62:0] FFC_FRAC_RST = 63'h0;
  localparam logic signed [16:0] FFC_ETRUE_RST = 17'sh00000;
  localparam logic [3:0] FFC_BYTES_RST = 4'h0;
  localparam int FFC_LATENCY = 1;
endpackage : ffc_pkg

/* tb_float_format_classifier.sv */
// Self-checking bench for the format classifier, one task per scenario.
// Assumes the partner model adds one register stage before the classifier.
`timescale 1ns/10ps
module tb_float_format_classifier;
  logic core_clk_in, rst_b_in, go, op_valid_in, res_valid_out, sign_out;
  logic int_bit_out, is_zero_out, is_denorm_out, is_inf_out, is_snan_out;
  logic is_qnan_out, is_indef_out, scalar_ok_out, simd_ok_out;
  logic [1:0]         fmt, op_fmt_in;
  logic [79:0]        dat, op_data_in;
  logic [14:0]        exp_biased_out;
  logic signed [16:0] exp_true_out;
  logic [62:0]        frac_out;
  logic [3:0]         mem_bytes_out;
  int                 fails = 0;
  int                 samples_checked = 0;
  ffc_feed i_ffc_feed (.clk_in(core_clk_in), .go_in(go), .fmt_in(fmt),
    .data_in(dat), .valid_out(op_valid_in), .fmt_out(op_fmt_in),
    .data_out(op_data_in));
  ffc_classifier i_ffc_classifier (.core_clk_in, .rst_b_in, .op_valid_in,
    .op_fmt_in, .op_data_in, .res_valid_out, .sign_out, .exp_biased_out,
    .exp_true_out, .int_bit_out, .frac_out, .is_zero_out, .is_denorm_out,
    .is_inf_out, .is_snan_out, .is_qnan_out, .is_indef_out, .mem_bytes_out,
    .scalar_ok_out, .simd_ok_out);
  task automatic chk(input string nm, input logic [79:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // Offer one operand, then wait a bounded time for its result
  task automatic send(input logic [1:0] f, input logic [79:0] d);
    int n;
    @(posedge core_clk_in);
    go <= 1'b1;
    fmt <= f;
    dat <= d;
    @(posedge core_clk_in);
    go <= 1'b0;
    n = 0;
    do begin
      @(posedge core_clk_in);
      #1;
      n++;
    end while (res_valid_out !== 1'b1 && n < 4);
    chk("valid", res_valid_out, 1'b1);
  endtask : send
  // Flags are zero, denorm, inf, snan, qnan, indefinite from the top
  task automatic fields(input string t, input logic s, input logic [14:0] eb,
    input logic [16:0] et, input logic ib, input logic [62:0] fr,
    input logic [5:0] fl, input logic [3:0] by, input logic sc, sm);
    chk("sign", sign_out, s);
    chk("ebias", exp_biased_out, eb);
    chk("etrue", {63'h0, exp_true_out}, {63'h0, et});
    chk("intbit", int_bit_out, ib);
    chk("frac", frac_out, fr);
    chk("class", {is_zero_out, is_denorm_out, is_inf_out, is_snan_out,
      is_qnan_out, is_indef_out}, fl);
    chk("bytes", mem_bytes_out, by);
    chk("units", {scalar_ok_out, simd_ok_out}, {sc, sm});
    $display("test %s done", t);
  endtask : fields
  task automatic t_single_one;
    send(2'h0, 80'h3F80_0000);
    fields("single_one", 0, 15'h7F, 17'h0, 1, 63'h0, 6'h0, 4'h4, 1, 1);
  endtask : t_single_one
  task automatic t_single_zero;
    send(2'h0, 80'h0);
    fields("single_zero", 0, 15'h0, 17'h1FF81, 0, 63'h0, 6'h20, 4'h4, 1, 1);
  endtask : t_single_zero
  // Largest negative denormal: hidden bit must read zero
  task automatic t_double_denorm;
    send(2'h1, 80'h800F_FFFF_FFFF_FFFF);
    fields("double_denorm", 1, 15'h0, 17'h1FC01, 0,
      {52'hF_FFFF_FFFF_FFFF, 11'h0}, 6'h10, 4'h8, 1, 1);
  endtask : t_double_denorm
  task automatic t_double_inf;
    send(2'h1, 80'h7FF0_0000_0000_0000);
    fields("double_inf", 0, 15'h7FF, 17'h00400, 1, 63'h0, 6'h08, 4'h8, 1, 1);
  endtask : t_double_inf
  // Only the lowest fraction bit set, so the top-bit test is exercised
  task automatic t_ext_snan;
    send(2'h2, {1'b0, 15'h7FFF, 1'b1, 63'h1});
    fields("ext_snan", 0, 15'h7FFF, 17'h04000, 1, 63'h1, 6'h04, 4'hA,
      1, 0);
  endtask : t_ext_snan
  // Reset in mid-run must return every result to zero
  task automatic t_mid_reset;
    @(posedge core_clk_in);
    rst_b_in <= 1'b0;
    repeat (2) @(posedge core_clk_in);
    #1;
    chk("rst_flags", {res_valid_out, sign_out, int_bit_out, is_zero_out,
      is_denorm_out, is_inf_out, is_snan_out, is_qnan_out, is_indef_out,
      scalar_ok_out, simd_ok_out}, 11'h000);
    chk("rst_frac", frac_out, 63'h0);
    chk("rst_exp", {exp_biased_out, exp_true_out, mem_bytes_out}, 36'h0);
    @(posedge core_clk_in);
    rst_b_in <= 1'b1;
    $display("test mid_reset done");
  endtask : t_mid_reset
  // Integer bit clear with only bit 62 set: both positions are seen
  task automatic t_ext_denorm;
    send(2'h2, {1'b1, 15'h0000, 1'b0, 63'h4000_0000_0000_0000});
    fields("ext_denorm", 1, 15'h0, 17'h1C001, 0,
      63'h4000_0000_0000_0000, 6'h10, 4'hA, 1, 0);
  endtask : t_ext_denorm
  // Positive quiet NaN with a stray low bit: not the indefinite value
  task automatic t_double_qnan;
    send(2'h1, 80'h7FF8_0000_0000_0001);
    fields("double_qnan", 0, 15'h7FF, 17'h00400, 1,
      {52'h8_0000_0000_0001, 11'h000}, 6'h02, 4'h8, 1, 1);
  endtask : t_double_qnan
  task automatic t_indefinite;
    send(2'h0, 80'hFFC0_0000);
    fields("indefinite", 1, 15'hFF, 17'h00080, 1, {1'b1, 62'h0}, 6'h03,
      4'h4, 1, 1);
    // Result stands while the feed shows stale inverted data
    @(posedge core_clk_in);
    #1;
    chk("pulse", res_valid_out, 1'b0);
    chk("hold_class", {is_qnan_out, is_indef_out}, 2'h3);
  endtask : t_indefinite
  task automatic t_reserved;
    send(2'h3, 80'hFFC0_0000);
    chk("rsv_class", {is_zero_out, is_denorm_out, is_inf_out, is_snan_out,
      is_qnan_out, is_indef_out}, 6'h00);
    chk("rsv_bytes", mem_bytes_out, 4'h0);
    chk("rsv_units", {scalar_ok_out, simd_ok_out}, 2'h0);
    $display("test reserved done");
  endtask : t_reserved
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish
  initial begin
    core_clk_in = 1'b0;
    forever #2 core_clk_in = ~core_clk_in;
  end
  // Watchdog sized well beyond the few dozen cycles the tests need
  initial begin
    #4000;
    fails++;
    tally_and_finish();
  end
  initial begin
    rst_b_in = 1'b0;
    go = 1'b0;
    fmt = 2'h0;
    dat = 80'h0;
    repeat (4) @(posedge core_clk_in);
    rst_b_in <= 1'b1;
    t_single_one();
    t_single_zero();
    t_double_denorm();
    t_double_inf();
    t_ext_snan();
    t_mid_reset();
    t_ext_denorm();
    t_double_qnan();
    t_indefinite();
    t_reserved();
    tally_and_finish();
  end
endmodule : tb_float_format_classifier
